// ---- rtl/mcr_pkg.sv ----
/*
  Shared constants, types and arithmetic for the meter calibration registers.
  Assumes a single device clock and 24-bit register words on register page 16.
*/
package mcr_pkg;

  // ----------------------------------------------------------------
  // Word format and register map
  // ----------------------------------------------------------------
  localparam int MCR_W = 24;
  localparam logic [5:0] MCR_PAGE = 6'h10;
  localparam logic [5:0] ADDR_CURRENT1_DC_OFFSET = 6'h20;
  localparam logic [5:0] ADDR_CURRENT1_GAIN = 6'h21;
  localparam logic [5:0] ADDR_VOLTAGE1_DC_OFFSET = 6'h22;
  localparam logic [5:0] ADDR_VOLTAGE1_GAIN = 6'h23;
  localparam logic [5:0] ADDR_ACTIVE_POWER1_OFFSET = 6'h24;
  localparam logic [5:0] ADDR_REACTIVE_POWER1_OFFSET = 6'h26;
  localparam logic [5:0] ADDR_CURRENT2_DC_OFFSET = 6'h27;
  localparam logic [5:0] ADDR_CURRENT2_GAIN = 6'h28;
  localparam logic [5:0] ADDR_VOLTAGE2_DC_OFFSET = 6'h29;
  localparam logic [5:0] ADDR_VOLTAGE2_GAIN = 6'h2A;
  localparam logic [5:0] ADDR_ACTIVE_POWER2_OFFSET = 6'h2B;
  localparam logic [5:0] ADDR_REACTIVE_POWER2_OFFSET = 6'h2D;

  // ----------------------------------------------------------------
  // Reset values and fixed-point limits
  // ----------------------------------------------------------------
  localparam logic [23:0] MCR_OFFSET_RESET = 24'h000000;
  localparam logic [23:0] MCR_GAIN_RESET = 24'h400000;
  localparam logic [23:0] MCR_POS_MAX = 24'h7FFFFF;
  localparam logic [23:0] MCR_NEG_MAX = 24'h800000;
  localparam logic [23:0] MCR_GAIN_MAX = 24'hFFFFFF;
  // Reciprocal of Q2.22 needs dividend 2^44, taken one bit per step
  localparam logic [5:0] MCR_DIV_STEPS = 6'h2D;

  // Input index: 0 current1, 1 voltage1, 2 current2, 3 voltage2
  localparam logic [1:0] IDX_CURRENT1 = 2'h0;
  localparam logic [1:0] IDX_VOLTAGE1 = 2'h1;
  localparam logic [1:0] IDX_CURRENT2 = 2'h2;
  localparam logic [1:0] IDX_VOLTAGE2 = 2'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MCR_IDLE = 2'b00,
    MCR_PICK = 2'b01,
    MCR_WAIT = 2'b10
  } mcr_state_t;

  typedef struct packed {
    logic [3:0][23:0] dc_off;
    logic [3:0][23:0] gain;
    logic [1:0][23:0] p_off;
    logic [1:0][23:0] q_off;
    logic [1:0][23:0] avg_p;
    logic [1:0][23:0] avg_q;
    logic avg_valid;
    logic [23:0] rd_data;
    logic rd_valid;
    mcr_state_t state;
    logic [3:0] pend;
    logic [1:0] gidx;
    logic div_start;
  } mcr_main_t;

  typedef struct packed {
    logic run;
    logic [5:0] cnt;
    logic [23:0] rem;
    logic [23:0] quo;
    logic ovf;
    logic [23:0] divisor;
    logic [23:0] result;
    logic done;
  } mcr_div_t;

  // ----------------------------------------------------------------
  // Saturating arithmetic on signed fractions
  // ----------------------------------------------------------------
  function automatic logic [23:0] sat_add(input logic [23:0] a, input logic [23:0] b);
    logic [24:0] sum;
    sum = {a[23], a} + {b[23], b};
    if (sum[24] != sum[23])
      sat_add = sum[24] ? MCR_NEG_MAX : MCR_POS_MAX;
    else
      sat_add = sum[23:0];
  endfunction : sat_add

  function automatic logic [23:0] neg_sat(input logic [23:0] a);
    if (a == MCR_NEG_MAX)
      neg_sat = MCR_POS_MAX;
    else
      neg_sat = 24'(~a + 24'h000001);
  endfunction : neg_sat

endpackage : mcr_pkg

// ---- rtl/mcr_recip.sv ----
/*
  Sequential reciprocal of an unsigned Q2.22 gain, result in Q2.22.
  Assumes start is a one-cycle pulse given only while busy is low.
*/
`timescale 1ns/1ps
module mcr_recip (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [23:0] divisor,
  output logic busy,
  output logic done,
  output logic [23:0] result
);

  mcr_pkg::mcr_div_t s_reg;
  mcr_pkg::mcr_div_t s_next;
  logic [24:0] rem_sh;

  // ----------------------------------------------------------------
  // Restoring division of 2^44 by the gain
  // ----------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    s_next.done = 1'b0;
    rem_sh = {s_reg.rem, (s_reg.cnt == 6'h00)};
    if (start && !s_reg.run)
    begin
      s_next.run = 1'b1;
      s_next.cnt = 6'h00;
      s_next.rem = 24'h000000;
      s_next.quo = 24'h000000;
      s_next.ovf = 1'b0;
      s_next.divisor = divisor;
    end
    else if (s_reg.run)
    begin
      s_next.ovf = s_reg.ovf | s_reg.quo[23];
      if (rem_sh >= {1'b0, s_reg.divisor})
      begin
        s_next.rem = 24'(rem_sh - {1'b0, s_reg.divisor});
        s_next.quo = {s_reg.quo[22:0], 1'b1};
      end
      else
      begin
        s_next.rem = rem_sh[23:0];
        s_next.quo = {s_reg.quo[22:0], 1'b0};
      end
      s_next.cnt = 6'(s_reg.cnt + 6'h01);
      if (s_reg.cnt == 6'(mcr_pkg::MCR_DIV_STEPS - 6'h01))
      begin
        // Results of four and above clamp to the largest gain
        s_next.run = 1'b0;
        s_next.done = 1'b1;
        s_next.result = (s_next.ovf || s_reg.divisor == 24'h000000) ?
                        mcr_pkg::MCR_GAIN_MAX : s_next.quo;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign busy = s_reg.run;
  assign done = s_reg.done;
  assign result = s_reg.result;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  recip_exact_a: assert property (@(posedge clock) disable iff (!rst_n)
    done && result != mcr_pkg::MCR_GAIN_MAX |->
      ({24'h000000, result} * {24'h000000, s_reg.divisor} <= 48'h100000000000) &&
      ({24'h000000, result} * {24'h000000, s_reg.divisor} + {24'h000000, s_reg.divisor}
        > 48'h100000000000))
    else $error("reciprocal result is not the floor of 2^44 over the gain");

  recip_latency_a: assert property (@(posedge clock) disable iff (!rst_n)
    start && !busy |=> ##44 busy ##1 done)
    else $error("reciprocal did not finish in 45 cycles");

endmodule : mcr_recip

// ---- rtl/mcr_regs.sv ----
/*
  Calibration register bank: DC offsets, gains and average power offsets
  for two current/voltage channel pairs, written by host or calibration.
  Assumes register port and calibration strobes are synchronous to clock.
*/
// Contract
// - DC offsets reset to zero
// - DC calibration loads negated measured offset
// - Host writes replace DC offset contents
// - DC offsets are signed Q1.23 fractions
// - Gains reset to unity 0x400000
// - Gain calibration loads reciprocal of measured gain
// - Gains are unsigned Q2.22 below four
// - Active average equals averaged plus offset
// - Reactive average equals averaged plus offset
// - Power offsets signed fractions, reset zero
// - Two channel sets on page 16, 32-45
`timescale 1ns/1ps
module mcr_regs (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [5:0] reg_page,
  input wire logic [5:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [23:0] reg_wr_data,
  input wire logic reg_rd_en,
  output logic [23:0] reg_rd_data,
  output logic reg_rd_valid,
  input wire logic [3:0] cal_select,
  input wire logic cal_dc_load,
  input wire logic cal_gain_start,
  output logic cal_gain_busy,
  input wire logic [23:0] meas_dc_current1,
  input wire logic [23:0] meas_dc_voltage1,
  input wire logic [23:0] meas_dc_current2,
  input wire logic [23:0] meas_dc_voltage2,
  input wire logic [23:0] meas_gain_current1,
  input wire logic [23:0] meas_gain_voltage1,
  input wire logic [23:0] meas_gain_current2,
  input wire logic [23:0] meas_gain_voltage2,
  output logic [23:0] current1_dc_offset,
  output logic [23:0] current1_gain,
  output logic [23:0] voltage1_dc_offset,
  output logic [23:0] voltage1_gain,
  output logic [23:0] current2_dc_offset,
  output logic [23:0] current2_gain,
  output logic [23:0] voltage2_dc_offset,
  output logic [23:0] voltage2_gain,
  input wire logic power_in_valid,
  input wire logic [23:0] raw_active_power1,
  input wire logic [23:0] raw_reactive_power1,
  input wire logic [23:0] raw_active_power2,
  input wire logic [23:0] raw_reactive_power2,
  output logic [23:0] average_active_power1,
  output logic [23:0] average_reactive_power1,
  output logic [23:0] average_active_power2,
  output logic [23:0] average_reactive_power2,
  output logic average_valid
);

  mcr_pkg::mcr_main_t s_reg;
  mcr_pkg::mcr_main_t s_next;
  logic [3:0][23:0] meas_dc;
  logic [3:0][23:0] meas_gain;
  logic [1:0][23:0] raw_p;
  logic [1:0][23:0] raw_q;
  logic page_hit;
  logic div_busy;
  logic div_done;
  logic [23:0] div_result;

  assign meas_dc = {meas_dc_voltage2, meas_dc_current2, meas_dc_voltage1, meas_dc_current1};
  assign meas_gain = {meas_gain_voltage2, meas_gain_current2, meas_gain_voltage1,
                      meas_gain_current1};
  assign raw_p = {raw_active_power2, raw_active_power1};
  assign raw_q = {raw_reactive_power2, raw_reactive_power1};
  assign page_hit = (reg_page == mcr_pkg::MCR_PAGE);

  // ----------------------------------------------------------------
  // Register read decode
  // ----------------------------------------------------------------
  function automatic logic [23:0] read_word(input mcr_pkg::mcr_main_t s,
                                            input logic [5:0] addr);
    case (addr)
      mcr_pkg::ADDR_CURRENT1_DC_OFFSET: read_word = s.dc_off[mcr_pkg::IDX_CURRENT1];
      mcr_pkg::ADDR_CURRENT1_GAIN: read_word = s.gain[mcr_pkg::IDX_CURRENT1];
      mcr_pkg::ADDR_VOLTAGE1_DC_OFFSET: read_word = s.dc_off[mcr_pkg::IDX_VOLTAGE1];
      mcr_pkg::ADDR_VOLTAGE1_GAIN: read_word = s.gain[mcr_pkg::IDX_VOLTAGE1];
      mcr_pkg::ADDR_ACTIVE_POWER1_OFFSET: read_word = s.p_off[0];
      mcr_pkg::ADDR_REACTIVE_POWER1_OFFSET: read_word = s.q_off[0];
      mcr_pkg::ADDR_CURRENT2_DC_OFFSET: read_word = s.dc_off[mcr_pkg::IDX_CURRENT2];
      mcr_pkg::ADDR_CURRENT2_GAIN: read_word = s.gain[mcr_pkg::IDX_CURRENT2];
      mcr_pkg::ADDR_VOLTAGE2_DC_OFFSET: read_word = s.dc_off[mcr_pkg::IDX_VOLTAGE2];
      mcr_pkg::ADDR_VOLTAGE2_GAIN: read_word = s.gain[mcr_pkg::IDX_VOLTAGE2];
      mcr_pkg::ADDR_ACTIVE_POWER2_OFFSET: read_word = s.p_off[1];
      mcr_pkg::ADDR_REACTIVE_POWER2_OFFSET: read_word = s.q_off[1];
      default: read_word = 24'h000000;
    endcase
  endfunction : read_word

  // Lowest pending input of a gain calibration
  function automatic logic [1:0] first_set(input logic [3:0] m);
    if (m[0])
      first_set = 2'h0;
    else if (m[1])
      first_set = 2'h1;
    else if (m[2])
      first_set = 2'h2;
    else
      first_set = 2'h3;
  endfunction : first_set

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    s_next.rd_valid = 1'b0;
    s_next.avg_valid = 1'b0;
    s_next.div_start = 1'b0;

    // Host writes come first so calibration results win a collision
    if (reg_wr_en && page_hit)
    begin
      case (reg_addr)
        mcr_pkg::ADDR_CURRENT1_DC_OFFSET: s_next.dc_off[0] = reg_wr_data;
        mcr_pkg::ADDR_CURRENT1_GAIN: s_next.gain[0] = reg_wr_data;
        mcr_pkg::ADDR_VOLTAGE1_DC_OFFSET: s_next.dc_off[1] = reg_wr_data;
        mcr_pkg::ADDR_VOLTAGE1_GAIN: s_next.gain[1] = reg_wr_data;
        mcr_pkg::ADDR_ACTIVE_POWER1_OFFSET: s_next.p_off[0] = reg_wr_data;
        mcr_pkg::ADDR_REACTIVE_POWER1_OFFSET: s_next.q_off[0] = reg_wr_data;
        mcr_pkg::ADDR_CURRENT2_DC_OFFSET: s_next.dc_off[2] = reg_wr_data;
        mcr_pkg::ADDR_CURRENT2_GAIN: s_next.gain[2] = reg_wr_data;
        mcr_pkg::ADDR_VOLTAGE2_DC_OFFSET: s_next.dc_off[3] = reg_wr_data;
        mcr_pkg::ADDR_VOLTAGE2_GAIN: s_next.gain[3] = reg_wr_data;
        mcr_pkg::ADDR_ACTIVE_POWER2_OFFSET: s_next.p_off[1] = reg_wr_data;
        mcr_pkg::ADDR_REACTIVE_POWER2_OFFSET: s_next.q_off[1] = reg_wr_data;
        default: s_next.rd_valid = 1'b0;
      endcase
    end

    if (reg_rd_en)
    begin
      s_next.rd_data = page_hit ? read_word(s_reg, reg_addr) : 24'h000000;
      s_next.rd_valid = 1'b1;
    end

    // DC calibration: negate the measured offset, signed Q1.23
    if (cal_dc_load)
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (cal_select[i])
          s_next.dc_off[i] = mcr_pkg::neg_sat(meas_dc[i]);
      end
    end

    // Gain calibration walks the selected inputs through the divider
    case (s_reg.state)
      mcr_pkg::MCR_IDLE:
      begin
        if (cal_gain_start && cal_select != 4'h0)
        begin
          s_next.pend = cal_select;
          s_next.state = mcr_pkg::MCR_PICK;
        end
      end
      mcr_pkg::MCR_PICK:
      begin
        s_next.gidx = first_set(s_reg.pend);
        s_next.div_start = 1'b1;
        s_next.state = mcr_pkg::MCR_WAIT;
      end
      mcr_pkg::MCR_WAIT:
      begin
        if (div_done)
        begin
          s_next.gain[s_reg.gidx] = div_result;
          s_next.pend[s_reg.gidx] = 1'b0;
          s_next.state = (s_next.pend == 4'h0) ? mcr_pkg::MCR_IDLE : mcr_pkg::MCR_PICK;
        end
      end
      default: s_next.state = mcr_pkg::MCR_IDLE;
    endcase

    // Averaged power plus offset, clamped at the fraction limits
    if (power_in_valid)
    begin
      for (int c = 0; c < 2; c++)
      begin
        s_next.avg_p[c] = mcr_pkg::sat_add(raw_p[c], s_reg.p_off[c]);
        s_next.avg_q[c] = mcr_pkg::sat_add(raw_q[c], s_reg.q_off[c]);
      end
      s_next.avg_valid = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_reg <= '0;
      s_reg.dc_off <= {4{mcr_pkg::MCR_OFFSET_RESET}};
      s_reg.gain <= {4{mcr_pkg::MCR_GAIN_RESET}};
      s_reg.p_off <= {2{mcr_pkg::MCR_OFFSET_RESET}};
      s_reg.q_off <= {2{mcr_pkg::MCR_OFFSET_RESET}};
      s_reg.state <= mcr_pkg::MCR_IDLE;
    end
    else
      s_reg <= s_next;
  end

  mcr_recip u_recip (
    .clock(clock),
    .rst_n(rst_n),
    .start(s_reg.div_start),
    .divisor(meas_gain[s_reg.gidx]),
    .busy(div_busy),
    .done(div_done),
    .result(div_result)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rd_data = s_reg.rd_data;
  assign reg_rd_valid = s_reg.rd_valid;
  assign cal_gain_busy = (s_reg.state != mcr_pkg::MCR_IDLE);
  assign current1_dc_offset = s_reg.dc_off[mcr_pkg::IDX_CURRENT1];
  assign voltage1_dc_offset = s_reg.dc_off[mcr_pkg::IDX_VOLTAGE1];
  assign current2_dc_offset = s_reg.dc_off[mcr_pkg::IDX_CURRENT2];
  assign voltage2_dc_offset = s_reg.dc_off[mcr_pkg::IDX_VOLTAGE2];
  assign current1_gain = s_reg.gain[mcr_pkg::IDX_CURRENT1];
  assign voltage1_gain = s_reg.gain[mcr_pkg::IDX_VOLTAGE1];
  assign current2_gain = s_reg.gain[mcr_pkg::IDX_CURRENT2];
  assign voltage2_gain = s_reg.gain[mcr_pkg::IDX_VOLTAGE2];
  assign average_active_power1 = s_reg.avg_p[0];
  assign average_active_power2 = s_reg.avg_p[1];
  assign average_reactive_power1 = s_reg.avg_q[0];
  assign average_reactive_power2 = s_reg.avg_q[1];
  assign average_valid = s_reg.avg_valid;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic first_reg;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      first_reg <= 1'b1;
    else
      first_reg <= 1'b0;
  end

  reset_values_a: assert property (@(posedge clock) disable iff (!rst_n)
    first_reg |-> s_reg.dc_off == {4{24'h000000}} && s_reg.gain == {4{24'h400000}}
      && s_reg.p_off == {2{24'h000000}} && s_reg.q_off == {2{24'h000000}})
    else $error("calibration registers not at reset values");

  dc_cal_load_a: assert property (@(posedge clock) disable iff (!rst_n)
    cal_dc_load && cal_select[2] |=> current2_dc_offset == mcr_pkg::neg_sat($past(meas_dc[2])))
    else $error("DC calibration did not load the negated offset");

  dc_sign_flip_a: assert property (@(posedge clock) disable iff (!rst_n)
    cal_dc_load && cal_select[1] && meas_dc[1] != 24'h000000 |=>
      voltage1_dc_offset[23] != $past(meas_dc[1][23]))
    else $error("DC calibration result has the wrong sign");

  host_write_a: assert property (@(posedge clock) disable iff (!rst_n)
    reg_wr_en && page_hit && reg_addr == mcr_pkg::ADDR_VOLTAGE2_DC_OFFSET && !cal_dc_load
      |=> voltage2_dc_offset == $past(reg_wr_data))
    else $error("host write to DC offset not stored");

  gain_cal_done_a: assert property (@(posedge clock) disable iff (!rst_n)
    s_reg.state == mcr_pkg::MCR_PICK |=> s_reg.state == mcr_pkg::MCR_WAIT
      ##[45:48] s_reg.state != mcr_pkg::MCR_WAIT)
    else $error("gain calibration step did not complete in time");

  gain_store_a: assert property (@(posedge clock) disable iff (!rst_n)
    s_reg.state == mcr_pkg::MCR_WAIT && div_done |=>
      s_reg.gain[$past(s_reg.gidx)] == $past(div_result))
    else $error("gain register not loaded with the reciprocal");

  active_sum_a: assert property (@(posedge clock) disable iff (!rst_n)
    power_in_valid |=> average_valid &&
      average_active_power1 == mcr_pkg::sat_add($past(raw_p[0]), $past(s_reg.p_off[0])))
    else $error("active power average wrong");

  reactive_sum_a: assert property (@(posedge clock) disable iff (!rst_n)
    power_in_valid |=>
      average_reactive_power2 == mcr_pkg::sat_add($past(raw_q[1]), $past(s_reg.q_off[1])))
    else $error("reactive power average wrong");

  sum_clamp_a: assert property (@(posedge clock) disable iff (!rst_n)
    power_in_valid && !raw_p[1][23] && !s_reg.p_off[1][23] |=> !average_active_power2[23])
    else $error("positive offset sum wrapped negative");

  page_read_a: assert property (@(posedge clock) disable iff (!rst_n)
    reg_rd_en && page_hit && reg_addr == mcr_pkg::ADDR_CURRENT1_GAIN && !reg_wr_en
      && s_reg.state == mcr_pkg::MCR_IDLE |=> reg_rd_valid && reg_rd_data == current1_gain)
    else $error("read of a mapped register returned the wrong word");

  // Strobes, holds and divider activity
  rd_pulse_a: assert property (@(posedge clock) disable iff (!rst_n)
    !reg_rd_en
      |=> !reg_rd_valid)
    else $error("read valid without a read");

  page_miss_a: assert property (@(posedge clock) disable iff (!rst_n)
    reg_rd_en && !page_hit
      |=> reg_rd_data == 24'h000000)
    else $error("read off page not zero");

  gain_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    s_reg.state == mcr_pkg::MCR_IDLE && !reg_wr_en
      |=> $stable(s_reg.gain))
    else $error("gain changed while idle");

  dc_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    !cal_dc_load && !reg_wr_en
      |=> $stable(s_reg.dc_off))
    else $error("DC offset changed unasked");

  div_busy_a: assert property (@(posedge clock) disable iff (!rst_n)
    s_reg.state == mcr_pkg::MCR_WAIT && !s_reg.div_start && !div_done
      |-> div_busy)
    else $error("divider idle in a gain step");

endmodule : mcr_regs

// ---- sim/mcr_host_model.sv ----
/*
  Host side of the register port: single-word writes and reads.
  Assumes the bench calls its tasks; the block answers one cycle later.
*/
`timescale 1ns/1ps
module mcr_host_model (
  input wire logic clock,
  output logic [5:0] reg_page,
  output logic [5:0] reg_addr,
  output logic reg_wr_en,
  output logic [23:0] reg_wr_data,
  output logic reg_rd_en,
  input wire logic [23:0] reg_rd_data,
  input wire logic reg_rd_valid
);
  // ----
  // Idle port
  // ----
  initial
  begin
    reg_page = 6'h10;
    reg_addr = 6'h00;
    reg_wr_en = 1'b0;
    reg_wr_data = 24'h000000;
    reg_rd_en = 1'b0;
  end

  // ----
  // Accesses
  // ----
  task automatic write_word(input logic [5:0] page, input logic [5:0] addr,
    input logic [23:0] data);
    @(posedge clock);
    #1;
    reg_page = page;
    reg_addr = addr;
    reg_wr_data = data;
    reg_wr_en = 1'b1;
    @(posedge clock);
    #1;
    reg_wr_en = 1'b0;
    // Released address and data lines do not keep their last value; reg_page keeps it
    reg_addr = ~addr;
    reg_wr_data = ~data;
  endtask : write_word

  task automatic read_word(input logic [5:0] page, input logic [5:0] addr,
    output logic [23:0] data, output logic valid);
    @(posedge clock);
    #1;
    reg_page = page;
    reg_addr = addr;
    reg_rd_en = 1'b1;
    @(posedge clock);
    #1;
    data = reg_rd_data;
    valid = reg_rd_valid;
    reg_rd_en = 1'b0;
    reg_addr = ~addr;
  endtask : read_word
endmodule : mcr_host_model

// ---- sim/mcr_regs_bench.sv ----
/*
  Self-checking bench for the calibration register bank.
  Assumes the package, the design and the host model are compiled first.
*/
`timescale 1ns/1ps
module mcr_regs_bench;
  // ----
  // Signals
  // ----
  localparam int CYCLE_LIMIT = 5000;
  localparam logic [5:0] GAIN_ADDR [4] = '{6'h21, 6'h23, 6'h28, 6'h2A};
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] cal_select = 4'h0;
  logic cal_dc_load = 1'b0;
  logic cal_gain_start = 1'b0;
  logic power_in_valid = 1'b0;
  logic [3:0][23:0] meas_dc = {4{24'h000000}};
  logic [3:0][23:0] meas_gain = {4{24'h400000}};
  logic [1:0][23:0] raw_p = {2{24'h000000}};
  logic [1:0][23:0] raw_q = {2{24'h000000}};
  wire [5:0] reg_page, reg_addr;
  wire reg_wr_en, reg_rd_en, reg_rd_valid, cal_gain_busy, average_valid;
  wire [23:0] reg_wr_data, reg_rd_data;
  wire [3:0][23:0] dc_out, gain_out;
  wire [1:0][23:0] avg_p, avg_q;
  int err_total = 0;
  int cmp_count = 0;
  int cycles = 0;

  always #4 clock = ~clock;

  mcr_host_model u_mcr_host_model (.clock(clock), .reg_page(reg_page), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en),
    .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid));
  mcr_regs u_mcr_regs (.clock(clock), .rst_n(rst_n), .reg_page(reg_page), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en),
    .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid), .cal_select(cal_select),
    .cal_dc_load(cal_dc_load), .cal_gain_start(cal_gain_start), .cal_gain_busy(cal_gain_busy),
    .meas_dc_current1(meas_dc[0]), .meas_dc_voltage1(meas_dc[1]),
    .meas_dc_current2(meas_dc[2]), .meas_dc_voltage2(meas_dc[3]),
    .meas_gain_current1(meas_gain[0]), .meas_gain_voltage1(meas_gain[1]),
    .meas_gain_current2(meas_gain[2]), .meas_gain_voltage2(meas_gain[3]),
    .current1_dc_offset(dc_out[0]), .current1_gain(gain_out[0]),
    .voltage1_dc_offset(dc_out[1]), .voltage1_gain(gain_out[1]),
    .current2_dc_offset(dc_out[2]), .current2_gain(gain_out[2]),
    .voltage2_dc_offset(dc_out[3]), .voltage2_gain(gain_out[3]),
    .power_in_valid(power_in_valid), .raw_active_power1(raw_p[0]),
    .raw_reactive_power1(raw_q[0]), .raw_active_power2(raw_p[1]),
    .raw_reactive_power2(raw_q[1]), .average_active_power1(avg_p[0]),
    .average_reactive_power1(avg_q[0]), .average_active_power2(avg_p[1]),
    .average_reactive_power2(avg_q[1]), .average_valid(average_valid));

  // ----
  // Helpers
  // ----
  function automatic logic [23:0] reset_of(input logic [5:0] a);
    reset_of = (a inside {6'h21, 6'h23, 6'h28, 6'h2A}) ? 24'h400000 : 24'h000000;
  endfunction : reset_of

  function automatic logic [23:0] pat(input logic [5:0] a);
    pat = {a, a, a, a} ^ 24'h5A5A5A;
  endfunction : pat

  function automatic logic [23:0] recip(input logic [23:0] g);
    logic [47:0] q;
    q = 48'h100000000000 / {24'h000000, g};
    recip = (q > 48'h000000FFFFFF) ? 24'hFFFFFF : q[23:0];
  endfunction : recip

  task automatic tick();
    @(posedge clock);
    #1;
  endtask : tick

  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic rd_check(input logic [5:0] page, input logic [5:0] a, input logic [23:0] exp);
    logic [23:0] d;
    logic v;
    u_mcr_host_model.read_word(page, a, d, v);
    check("rd_valid", {23'h000000, v}, 24'h000001);
    check("rd_data", d, exp);
  endtask : rd_check

  task automatic do_reset();
    rst_n = 1'b0;
    repeat (20) @(posedge clock);
    #1;
    rst_n = 1'b1;
  endtask : do_reset

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run

  // ----
  // Scenarios
  // ----
  task automatic test_reset();
    for (int i = 0; i < 14; i++)
      rd_check(6'h10, 6'(32 + i), reset_of(6'(32 + i)));
    for (int i = 0; i < 4; i++)
    begin
      check("dc_out", dc_out[i], 24'h000000);
      check("gain_out", gain_out[i], 24'h400000);
    end
    $display("test_reset done");
  endtask : test_reset

  task automatic test_write();
    logic [5:0] a;
    for (int i = 0; i < 14; i++)
      u_mcr_host_model.write_word(6'h10, 6'(32 + i), pat(6'(32 + i)));
    for (int i = 0; i < 14; i++)
    begin
      a = 6'(32 + i);
      rd_check(6'h10, a, (a inside {6'h25, 6'h2C}) ? 24'h000000 : pat(a));
    end
    for (int i = 0; i < 4; i++)
    begin
      check("gain_out", gain_out[i], pat(GAIN_ADDR[i]));
      check("dc_out", dc_out[i], pat(GAIN_ADDR[i] - 6'h01));
    end
    u_mcr_host_model.write_word(6'h11, 6'h20, 24'h123456);
    rd_check(6'h10, 6'h20, pat(6'h20));
    rd_check(6'h11, 6'h20, 24'h000000);
    $display("test_write done");
  endtask : test_write

  task automatic dc_load(input logic [3:0] sel);
    tick();
    cal_select = sel;
    cal_dc_load = 1'b1;
    tick();
    cal_dc_load = 1'b0;
  endtask : dc_load

  task automatic test_dc();
    meas_dc = {24'h400000, 24'hFFFFFF, 24'h800000, 24'h000100};
    dc_load(4'hF);
    check("dc_c1", dc_out[0], 24'hFFFF00);
    check("dc_v1", dc_out[1], 24'h7FFFFF);
    check("dc_c2", dc_out[2], 24'h000001);
    check("dc_v2", dc_out[3], 24'hC00000);
    meas_dc = {4{24'h000002}};
    dc_load(4'h1);
    check("dc_c1", dc_out[0], 24'hFFFFFE);
    check("dc_v2", dc_out[3], 24'hC00000);
    rd_check(6'h10, 6'h22, 24'h7FFFFF);
    $display("test_dc done");
  endtask : test_dc

  task automatic test_gain();
    int n;
    meas_gain = {24'h200000, 24'h100000, 24'h300000, 24'h400000};
    tick();
    cal_select = 4'hF;
    cal_gain_start = 1'b1;
    tick();
    cal_gain_start = 1'b0;
    check("busy", {23'h000000, cal_gain_busy}, 24'h000001);
    n = 0;
    while (cal_gain_busy !== 1'b0 && n < 300)
    begin
      tick();
      n++;
    end
    check("busy", {23'h000000, cal_gain_busy}, 24'h000000);
    for (int i = 0; i < 4; i++)
      check("gain_out", gain_out[i], recip(meas_gain[i]));
    rd_check(6'h10, 6'h2A, 24'h800000);
    $display("test_gain done");
  endtask : test_gain

  task automatic test_power();
    u_mcr_host_model.write_word(6'h10, 6'h24, 24'h100000);
    u_mcr_host_model.write_word(6'h10, 6'h26, 24'hF00000);
    u_mcr_host_model.write_word(6'h10, 6'h2B, 24'h7FFFFF);
    u_mcr_host_model.write_word(6'h10, 6'h2D, 24'h800000);
    raw_p = {24'h000010, 24'h200000};
    raw_q = {24'hFFFFFF, 24'h100000};
    tick();
    power_in_valid = 1'b1;
    tick();
    check("avg_valid", {23'h000000, average_valid}, 24'h000001);
    check("avg_p1", avg_p[0], 24'h300000);
    check("avg_q1", avg_q[0], 24'h000000);
    check("avg_p2", avg_p[1], 24'h7FFFFF);
    check("avg_q2", avg_q[1], 24'h800000);
    raw_p[0] = 24'h780000;
    tick();
    power_in_valid = 1'b0;
    check("avg_p1", avg_p[0], 24'h7FFFFF);
    check("avg_valid", {23'h000000, average_valid}, 24'h000001);
    tick();
    check("avg_valid", {23'h000000, average_valid}, 24'h000000);
    $display("test_power done");
  endtask : test_power

  // ----
  // Sequence and cycle limit
  // ----
  initial
  begin
    do_reset();
    test_reset();
    test_write();
    test_dc();
    test_gain();
    test_power();
    do_reset();
    test_reset();
    complete_run();
  end

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == CYCLE_LIMIT)
    begin
      err_total++;
      $display("FAIL cycle_limit expected %0d seen %0d", CYCLE_LIMIT - 1, cycles);
      complete_run();
    end
  end
endmodule : mcr_regs_bench
